// >>> shared/mfos_consts.svh
// Purpose: Constants of the multi-function output selector
// Assumes: Frequencies in units of 0.01 Hz
// Notes:   Byte addresses on the AXI4-Lite register bus
`ifndef MFOS_CONSTS_SVH
`define MFOS_CONSTS_SVH
// Register byte addresses
`define MFOS_ADDR_TRIP_MODE 8'h00
`define MFOS_ADDR_DETECT_FREQ 8'h04
`define MFOS_ADDR_DETECT_BAND 8'h08
`define MFOS_ADDR_SEL_BASE 8'h0C
`define MFOS_ADDR_DO_STATUS 8'h24
`define MFOS_ADDR_CARD_STATUS 8'h28
// Field positions
`define MFOS_TRIP_UV_BIT 0
`define MFOS_TRIP_OTHER_BIT 1
`define MFOS_TRIP_RESTART_BIT 2
`define MFOS_CARD_EXT_BIT 0
`define MFOS_CARD_OPT_BIT 1
// Output slots
`define MFOS_NUM_OUT 6
`define MFOS_NUM_BASE 3
`define MFOS_SLOT_OC 2
// Reset values
`define MFOS_RST_TRIP_MODE 3'h2
`define MFOS_RST_DETECT_FREQ 16'h0BB8
`define MFOS_RST_DETECT_BAND 16'h03E8
`define MFOS_RST_SEL_RELAY1 5'h1C
`define MFOS_RST_SEL_RELAY2 5'h0E
`define MFOS_RST_SEL_OC 5'h01
`define MFOS_RST_SEL_EXT 5'h00
// Bus responses
`define MFOS_RESP_OKAY 2'h0
`define MFOS_RESP_SLVERR 2'h2
`endif

// >>> shared/mfos_pkg.sv
// Purpose: Types of the multi-function output selector
// Assumes: Included with mfos_consts.svh
// Notes:   Flags come from drive logic on core_clk
package mfos_pkg;
    // Output function codes
    typedef enum logic [4:0] {
        MFOS_NONE = 5'h00, MFOS_FREQ_REACHED = 5'h01, MFOS_SET_MATCH = 5'h02,
        MFOS_OUT_BAND = 5'h03, MFOS_HYST = 5'h04, MFOS_MOTOR_OVL = 5'h05,
        MFOS_DRIVE_OVL = 5'h06, MFOS_UNDERLOAD = 5'h07, MFOS_FAN = 5'h08,
        MFOS_STALL = 5'h09, MFOS_OVERVOLT = 5'h0A, MFOS_UNDERVOLT = 5'h0B,
        MFOS_OVERHEAT = 5'h0C, MFOS_CMD_LOST = 5'h0D, MFOS_RUN = 5'h0E,
        MFOS_STOP = 5'h0F, MFOS_STEADY = 5'h10, MFOS_DRIVE_LINE = 5'h11,
        MFOS_MAINS_LINE = 5'h12, MFOS_SPEED_SEARCH = 5'h13, MFOS_STEP_PULSE = 5'h14,
        MFOS_SEQ_PULSE = 5'h15, MFOS_READY = 5'h16, MFOS_TRAVERSE_ACCEL_REACHED = 5'h17,
        MFOS_TRAVERSE_DECEL_REACHED = 5'h18, MFOS_TRIP = 5'h1C
    } mfos_code_t;
    // Drive state and fault flags
    typedef struct packed {
        logic run_cmd;
        logic volt_out;
        logic dc_brake;
        logic motor_ovl;
        logic drive_overload_flag;
        logic underload;
        logic fan_fault;
        logic stall;
        logic overheat;
        logic dc_over;
        logic dc_under;
        logic cmd_lost;
        logic opt_cmd_lost;
        logic steady;
        logic speed_search;
        logic drive_line_sel;
        logic mains_line_sel;
        logic step_pulse;
        logic seq_pulse;
        logic healthy;
        logic traverse_accel_reached;
        logic traverse_decel_reached;
        logic uv_trip;
        logic other_trip;
        logic restart_fail;
    } mfos_flags_t;
    // Frequencies in 0.01 Hz
    typedef struct packed {
        logic [15:0] set_freq;
        logic [15:0] out_freq;
    } mfos_freq_t;
endpackage

// >>> rtl/mfos_top.sv
// Purpose: Multi-function output selector with AXI4-Lite registers
// Assumes: Flags and frequencies arrive on core_clk; card pins are async
// Notes:   Slots 0,1 relays, 2 open collector, 3..5 extension relays
// Functional notes
// - Fault mode bit0 trips on undervoltage
// - Fault mode bit1 trips on other faults
// - Fault mode bit2 trips on final restart failure
// - Three outputs, three more with extension card
// - Status word shows three or six outputs
// - Code zero idle, or option controller drives
// - Code one: set-output gap below half band
// - Code two: set near detect and code one
// - Code three: output near detect frequency
// - Code four: hysteresis around detect frequency
// - Codes ten, eleven: bus over, undervoltage
// - Codes five-nine, twelve: warnings and faults
// - Code thirteen: any command source lost
// - Code fourteen: running, not DC braking
// - Code fifteen: stopped with no voltage
// - Codes sixteen, nineteen: steady, speed search
// - Codes seventeen, eighteen: bypass line selects
// - Codes twenty, twenty-one: sequence pulses
// - Code twenty-two: healthy, awaiting run
// - Code twenty-three: traverse accel reached
// - Code twenty-four: traverse decel reached
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mfos_consts.svh"

module mfos_top
    import mfos_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Drive side
    input wire mfos_flags_t drive_flags,
    input wire mfos_freq_t drive_freq,
    input wire logic ext_card_pin,
    input wire logic opt_ctl_pin,
    input wire logic [5:0] opt_ctl_out,
    output logic [5:0] do_out
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [2:0] trip_mode_reg;
    logic [15:0] detect_frequency_reg;
    logic [15:0] detect_band_width_reg;
    logic [4:0] sel_reg [`MFOS_NUM_OUT];
    logic [5:0] do_out_reg;
    logic [5:0] do_out_next;
    logic hyst_reg;
    logic ext_meta_reg;
    logic ext_card_reg;
    logic opt_meta_reg;
    logic opt_card_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Absolute difference of two frequencies
    function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction

    // ----------------------------------------
    // Card presence synchronisers
    // ----------------------------------------
    // Two flops on each card pin
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_meta_reg <= 1'b0;
            ext_card_reg <= 1'b0;
            opt_meta_reg <= 1'b0;
            opt_card_reg <= 1'b0;
        end else if (clk_en) begin
            ext_meta_reg <= ext_card_pin;
            ext_card_reg <= ext_meta_reg;
            opt_meta_reg <= opt_ctl_pin;
            opt_card_reg <= opt_meta_reg;
        end
    end

    // ----------------------------------------
    // Frequency detection
    // ----------------------------------------
    logic [15:0] half_band;
    logic freq_reached_detect;
    logic set_freq_match_detect;
    logic output_freq_band_detect;
    logic [16:0] hyst_low;

    // Shared comparisons
    assign half_band = {1'b0, detect_band_width_reg[15:1]};
    assign freq_reached_detect =
        abs_diff(drive_freq.set_freq, drive_freq.out_freq) < half_band;
    assign set_freq_match_detect = freq_reached_detect &&
        (abs_diff(drive_freq.set_freq, detect_frequency_reg) < half_band);
    assign output_freq_band_detect =
        abs_diff(detect_frequency_reg, drive_freq.out_freq) < half_band;
    assign hyst_low = {1'b0, detect_frequency_reg} - {1'b0, half_band};

    // Hysteresis: set at detect, clear at detect minus half band
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hyst_reg <= 1'b0;
        end else if (clk_en) begin
            if (drive_freq.out_freq >= detect_frequency_reg) begin
                hyst_reg <= 1'b1;
            end else if (!hyst_low[16] && ({1'b0, drive_freq.out_freq} <= hyst_low)) begin
                hyst_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Fault output
    // ----------------------------------------
    logic fault_active;

    // Trip classes gated by fault mode
    assign fault_active =
        (trip_mode_reg[`MFOS_TRIP_UV_BIT] && drive_flags.uv_trip) ||
        (trip_mode_reg[`MFOS_TRIP_OTHER_BIT] && drive_flags.other_trip) ||
        (trip_mode_reg[`MFOS_TRIP_RESTART_BIT] && drive_flags.restart_fail);

    // ----------------------------------------
    // Per-output function mux
    // ----------------------------------------
    logic [5:0] ext_mask;

    // Extension slots live only with the card
    assign ext_mask = ext_card_reg ? 6'h3F : 6'h07;

    for (genvar g = 0; g < `MFOS_NUM_OUT; g++) begin : g_out
        logic hit;
        // Function selected by this slot
        always_comb begin
            unique case (mfos_code_t'(sel_reg[g]))
                MFOS_NONE: hit = opt_card_reg && opt_ctl_out[g];
                MFOS_FREQ_REACHED: hit = freq_reached_detect;
                MFOS_SET_MATCH: hit = set_freq_match_detect;
                MFOS_OUT_BAND: hit = output_freq_band_detect;
                MFOS_HYST: hit = hyst_reg;
                MFOS_MOTOR_OVL: hit = drive_flags.motor_ovl;
                MFOS_DRIVE_OVL: hit = drive_flags.drive_overload_flag;
                MFOS_UNDERLOAD: hit = drive_flags.underload;
                MFOS_FAN: hit = drive_flags.fan_fault;
                MFOS_STALL: hit = drive_flags.stall;
                MFOS_OVERVOLT: hit = drive_flags.dc_over;
                MFOS_UNDERVOLT: hit = drive_flags.dc_under;
                MFOS_OVERHEAT: hit = drive_flags.overheat;
                MFOS_CMD_LOST: hit = drive_flags.cmd_lost || drive_flags.opt_cmd_lost;
                MFOS_RUN: hit = drive_flags.run_cmd && drive_flags.volt_out &&
                                !drive_flags.dc_brake;
                MFOS_STOP: hit = !drive_flags.run_cmd && !drive_flags.volt_out;
                MFOS_STEADY: hit = drive_flags.steady;
                MFOS_DRIVE_LINE: hit = drive_flags.drive_line_sel;
                MFOS_MAINS_LINE: hit = drive_flags.mains_line_sel;
                MFOS_SPEED_SEARCH: hit = drive_flags.speed_search;
                MFOS_STEP_PULSE: hit = drive_flags.step_pulse;
                MFOS_SEQ_PULSE: hit = drive_flags.seq_pulse;
                MFOS_READY: hit = drive_flags.healthy && !drive_flags.run_cmd;
                MFOS_TRAVERSE_ACCEL_REACHED: hit = drive_flags.traverse_accel_reached;
                MFOS_TRAVERSE_DECEL_REACHED: hit = drive_flags.traverse_decel_reached;
                MFOS_TRIP: hit = fault_active;
                default: hit = 1'b0;
            endcase
        end
        assign do_out_next[g] = hit && ext_mask[g];
    end

    // Outputs follow their condition every cycle that clk_en is high
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            do_out_reg <= 6'h00;
        end else if (clk_en) begin
            do_out_reg <= do_out_next;
        end
    end

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    logic aw_hs;
    logic w_hs;
    logic do_wr;
    logic aw_held_next;
    logic w_held_next;
    logic bvalid_next;
    logic wr_hit;
    logic [3:0] wr_slot;

    assign aw_hs = s_axi_awvalid && awready_reg;
    assign w_hs = s_axi_wvalid && wready_reg;
    assign do_wr = aw_held_reg && w_held_reg;
    assign aw_held_next = (aw_held_reg || aw_hs) && !do_wr;
    assign w_held_next = (w_held_reg || w_hs) && !do_wr;
    assign bvalid_next = do_wr || (bvalid_reg && !s_axi_bready);
    assign wr_slot = 4'((awaddr_reg - `MFOS_ADDR_SEL_BASE) >> 2);
    assign wr_hit = (awaddr_reg[1:0] == 2'h0) && (awaddr_reg <= `MFOS_ADDR_CARD_STATUS);

    // Address and data taken in either order
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `MFOS_RESP_OKAY;
        end else if (clk_en) begin
            if (aw_hs) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awready_reg <= !aw_held_next && !bvalid_next;
            wready_reg <= !w_held_next && !bvalid_next;
            bvalid_reg <= bvalid_next;
            if (do_wr) begin
                bresp_reg <= wr_hit ? `MFOS_RESP_OKAY : `MFOS_RESP_SLVERR;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            trip_mode_reg <= `MFOS_RST_TRIP_MODE;
            detect_frequency_reg <= `MFOS_RST_DETECT_FREQ;
            detect_band_width_reg <= `MFOS_RST_DETECT_BAND;
            sel_reg[0] <= `MFOS_RST_SEL_RELAY1;
            sel_reg[1] <= `MFOS_RST_SEL_RELAY2;
            sel_reg[2] <= `MFOS_RST_SEL_OC;
            sel_reg[3] <= `MFOS_RST_SEL_EXT;
            sel_reg[4] <= `MFOS_RST_SEL_EXT;
            sel_reg[5] <= `MFOS_RST_SEL_EXT;
        end else if (clk_en && do_wr) begin
            if (awaddr_reg == `MFOS_ADDR_TRIP_MODE) begin
                trip_mode_reg <= 3'(merge(32'(trip_mode_reg), wdata_reg, wstrb_reg));
            end
            if (awaddr_reg == `MFOS_ADDR_DETECT_FREQ) begin
                detect_frequency_reg <= 16'(merge(32'(detect_frequency_reg), wdata_reg, wstrb_reg));
            end
            if (awaddr_reg == `MFOS_ADDR_DETECT_BAND) begin
                detect_band_width_reg <= 16'(merge(32'(detect_band_width_reg), wdata_reg, wstrb_reg));
            end
            // Extension slots writable only with the card
            if (awaddr_reg >= `MFOS_ADDR_SEL_BASE && awaddr_reg < `MFOS_ADDR_DO_STATUS &&
                awaddr_reg[1:0] == 2'h0 && ext_mask[wr_slot[2:0]]) begin
                sel_reg[wr_slot[2:0]] <= 5'(merge(32'(sel_reg[wr_slot[2:0]]), wdata_reg, wstrb_reg));
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    logic ar_hs;
    logic rvalid_next;
    logic [31:0] rd_word;
    logic rd_err;
    logic [3:0] rd_slot;

    assign ar_hs = s_axi_arvalid && arready_reg;
    assign rvalid_next = ar_hs || (rvalid_reg && !s_axi_rready);
    assign rd_slot = 4'((s_axi_araddr - `MFOS_ADDR_SEL_BASE) >> 2);

    // Read decode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        if (s_axi_araddr[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end else if (s_axi_araddr == `MFOS_ADDR_TRIP_MODE) begin
            rd_word = 32'(trip_mode_reg);
        end else if (s_axi_araddr == `MFOS_ADDR_DETECT_FREQ) begin
            rd_word = 32'(detect_frequency_reg);
        end else if (s_axi_araddr == `MFOS_ADDR_DETECT_BAND) begin
            rd_word = 32'(detect_band_width_reg);
        end else if (s_axi_araddr >= `MFOS_ADDR_SEL_BASE && s_axi_araddr < `MFOS_ADDR_DO_STATUS) begin
            rd_word = ext_mask[rd_slot[2:0]] ? 32'(sel_reg[rd_slot[2:0]]) : 32'h0000_0000;
        end else if (s_axi_araddr == `MFOS_ADDR_DO_STATUS) begin
            rd_word = 32'(do_out_reg & ext_mask);
        end else if (s_axi_araddr == `MFOS_ADDR_CARD_STATUS) begin
            rd_word[`MFOS_CARD_EXT_BIT] = ext_card_reg;
            rd_word[`MFOS_CARD_OPT_BIT] = opt_card_reg;
        end else begin
            rd_err = 1'b1;
        end
    end

    // One read under way at a time
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `MFOS_RESP_OKAY;
        end else if (clk_en) begin
            arready_reg <= !rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_hs) begin
                rdata_reg <= rd_word;
                rresp_reg <= rd_err ? `MFOS_RESP_SLVERR : `MFOS_RESP_OKAY;
            end
        end
    end

    // ----------------------------------------
    // Port drive
    // ----------------------------------------
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign do_out = do_out_reg;

endmodule

`default_nettype wire

// >>> dv/mfos_properties.sv
// Purpose: Port-level checks of the output selector
// Assumes: Bus handshakes are made with clk_en high
// Notes:   Bound to mfos_top below the module
`timescale 1ns/1ps
`default_nettype none
module mfos_properties (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_card_pin,
    input wire logic [5:0] do_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Bus and card events
    sequence wr_taken;
        clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        clk_en && s_axi_arvalid && s_axi_arready;
    endsequence
    sequence no_card;
        (clk_en && !ext_card_pin) [*4];
    endsequence
    a_write_answer: assert property (wr_taken ##1 clk_en |=> s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response missing");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while response pending");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready while response pending");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before taken");
    a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("bad write response code");
    a_freeze_out: assert property (!clk_en |=> $stable(do_out))
        else $error("outputs moved while frozen");
    a_ext_mask: assert property (no_card |=> do_out[5:3] == 3'h0)
        else $error("extension outputs active without card");
    a_reset_clear: assert property ($fell(sys_rst) |-> do_out == 6'h00 && !s_axi_bvalid)
        else $error("state not cleared by reset");
endmodule
bind mfos_top mfos_properties i_props (.core_clk, .sys_rst, .clk_en, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_card_pin, .do_out);
`default_nettype wire

// >>> dv/mfos_relay_model.sv
// Purpose: External relay and contactor bank on the outputs
// Assumes: Coils driven by do_out
// Notes:   Contacts pick up one cycle after the coil
`timescale 1ns/1ps
`default_nettype none
module mfos_relay_model (
    input wire logic core_clk,
    input wire logic [5:0] coil,
    output logic [5:0] contact
);
    // Contact follows coil with pick-up delay
    always_ff @(posedge core_clk) begin
        contact <= coil;
    end
endmodule
`default_nettype wire

// >>> dv/mfos_tb_top.sv
// Purpose: Self-checking bench of the output selector
// Assumes: AXI4-Lite master, reference model in the bench
// Notes:   Random flags and codes from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "mfos_consts.svh"
module mfos_tb_top
    import mfos_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    mfos_flags_t drive_flags = '0;
    mfos_freq_t drive_freq = '0;
    logic ext_card_pin = 1'b1;
    logic opt_ctl_pin = 1'b0;
    logic [5:0] opt_ctl_out = 6'h00;
    logic [5:0] do_out;
    logic [5:0] contact;
    int bad_count = 0;
    int n_tests = 0;
    int sel[6];
    int det = 3000;
    int band = 1000;
    int tm = 2;
    int rst_tab[9] = '{2, 3000, 1000, 28, 14, 1, 0, 0, 0};
    logic hyst = 1'b0;
    logic [5:0] ev;
    logic [1:0] resp;
    logic [31:0] rd;

    mfos_top i_dut (.core_clk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .drive_flags, .drive_freq, .ext_card_pin, .opt_ctl_pin,
        .opt_ctl_out, .do_out);
    mfos_relay_model i_relays (.core_clk, .coil(do_out), .contact);

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    function automatic int dif(int a, int b);
        return (a > b) ? a - b : b - a;
    endfunction
    // Shared hysteresis latch on output frequency
    function automatic void hyst_step(int f);
        if (f >= det) hyst = 1'b1;
        else if (f <= det - band / 2) hyst = 1'b0;
    endfunction
    function automatic logic exp_bit(int i);
        int s;
        int o;
        int h;
        mfos_flags_t f;
        f = drive_flags;
        s = drive_freq.set_freq;
        o = drive_freq.out_freq;
        h = band / 2;
        if (i > 2 && !ext_card_pin) return 1'b0;
        case (sel[i])
            0: return opt_ctl_pin & opt_ctl_out[i];
            1: return dif(s, o) < h;
            2: return dif(s, det) < h && dif(s, o) < h;
            3: return dif(det, o) < h;
            4: return hyst;
            5: return f.motor_ovl;
            6: return f.drive_overload_flag;
            7: return f.underload;
            8: return f.fan_fault;
            9: return f.stall;
            10: return f.dc_over;
            11: return f.dc_under;
            12: return f.overheat;
            13: return f.cmd_lost | f.opt_cmd_lost;
            14: return f.run_cmd & f.volt_out & !f.dc_brake;
            15: return !f.run_cmd & !f.volt_out;
            16: return f.steady;
            17: return f.drive_line_sel;
            18: return f.mains_line_sel;
            19: return f.speed_search;
            20: return f.step_pulse;
            21: return f.seq_pulse;
            22: return f.healthy & !f.run_cmd;
            23: return f.traverse_accel_reached;
            24: return f.traverse_decel_reached;
            28: return (tm[0] & f.uv_trip)
                | (tm[1] & f.other_trip)
                | (tm[2] & f.restart_fail);
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic [5:0] exp_vec();
        logic [5:0] v;
        for (int i = 0; i < 6; i++) v[i] = exp_bit(i);
        return v;
    endfunction

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Write with address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // Read; rready offered with the address
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check(rd, e);
        check(s_axi_rresp, r);
    endtask

    // Watchdog: about 2000 cycles expected, cut at 20000
    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'h9998));
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (rst_tab[k]) rchk(8'(4 * k), rst_tab[k], 2'h0);
        rchk(8'h2C, 32'h0, 2'h2);
        wr(8'h02, 32'h1);
        check(resp, 2'h2);
        wr(`MFOS_ADDR_DO_STATUS, 32'h3F);
        check(resp, 2'h0);
        // Random codes, bands, flags and frequencies
        repeat (40) begin
            tm = $urandom_range(7);
            det = $urandom_range(5000, 2000);
            wr(8'h00, tm);
            wr(8'h04, det);
            hyst_step(drive_freq.out_freq);
            band = $urandom_range(3999);
            wr(8'h08, band);
            hyst_step(drive_freq.out_freq);
            for (int i = 0; i < 6; i++) begin
                sel[i] = $urandom_range(31);
                wr(8'(12 + 4 * i), sel[i]);
            end
            @(posedge core_clk);
            drive_flags <= 25'($urandom);
            drive_freq.set_freq <= 16'(det + $urandom_range(3000) - 1500);
            drive_freq.out_freq <= 16'(det + $urandom_range(3000) - 1500);
            opt_ctl_pin <= 1'($urandom);
            opt_ctl_out <= 6'($urandom);
            repeat (4) @(posedge core_clk);
            hyst_step(drive_freq.out_freq);
            ev = exp_vec();
            check(do_out, ev);
            rchk(`MFOS_ADDR_DO_STATUS, ev, 2'h0);
            rchk(`MFOS_ADDR_CARD_STATUS, {opt_ctl_pin, ext_card_pin}, 2'h0);
        end
        // Frozen enable holds outputs
        @(posedge core_clk);
        clk_en <= 1'b0;
        drive_flags <= ~drive_flags;
        repeat (3) @(posedge core_clk);
        check(do_out, ev);
        clk_en <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(do_out, exp_vec());
        // Extension card removed
        ext_card_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        wr(8'h18, 32'h16);
        check(resp, 2'h0);
        rchk(8'h18, 32'h0, 2'h0);
        ev = exp_vec();
        check(do_out, ev);
        check(contact, ev);
        rchk(`MFOS_ADDR_DO_STATUS, ev, 2'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
